// ==== scc_clock_control.v ====
// system clock source selection, divider, oscillator control and apb registers
`timescale 1ns/1ps
`default_nettype none
`include "scc_defines.vh"

module scc_clock_control #(
  parameter [6:0] TRIM_FACTORY     = 7'h40,
  parameter       EXT_VALID_TICKS  = 1024
) (
  input  wire        sys_clk,
  input  wire        rst_b,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // oscillator ticks, one-cycle enables
  input  wire        precOscTick,
  input  wire        extOscTick,
  input  wire        lpOscTick,
  input  wire        rtcOscTick,
  // oscillator controls
  output reg         precOscEnable,
  output reg  [6:0]  precTrim,
  output reg  [2:0]  precSpreadStep,
  output reg         lpOscEnable,
  output reg         extOscEnable,
  output reg  [1:0]  extOscMode,
  output reg  [2:0]  extDriveLevel,
  output reg         extUsesPinA,
  // clock enables out
  output reg         coreClkEn,
  output reg         extPeriphClkEn
);

  localparam SW_IDLE     = 2'b00;
  localparam SW_WAIT_OLD = 2'b01;
  localparam SW_WAIT_NEW = 2'b10;

  localparam VCNT_W = 11;

  // ---------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------
  reg rstMeta;
  reg rstSync;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // legal source codes
  function legalSource;
    input [2:0] code;
    begin
      legalSource = (code == `SCC_SRC_PREC) || (code == `SCC_SRC_EXT) ||
                    (code == `SCC_SRC_RTC) || (code == `SCC_SRC_LP);
    end
  endfunction

  function pickTick;
    input [2:0] code;
    input       tPrec;
    input       tExt;
    input       tRtc;
    input       tLp;
    begin
      case (code)
        `SCC_SRC_PREC: pickTick = tPrec;
        `SCC_SRC_EXT:  pickTick = tExt;
        `SCC_SRC_RTC:  pickTick = tRtc;
        `SCC_SRC_LP:   pickTick = tLp;
        default:       pickTick = 1'b0;
      endcase
    end
  endfunction

  // terminal count of divide by 2^code
  function [`SCC_DIV_CNT_W-1:0] divLimit;
    input [2:0] code;
    begin
      divLimit = ~({`SCC_DIV_CNT_W{1'b1}} << code);
    end
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [2:0] selReg;
  reg  [2:0] divReg;
  reg        divApplied;
  reg        spreadEnable;
  reg  [VCNT_W-1:0] validCnt;
  reg        extValid;

  wire apbAccess = psel & penable & ~pready;
  wire apbDone   = psel & penable & pready;
  wire wrDone    = apbDone & pwrite;

  wire wrClk  = wrDone && (paddr == `SCC_ADDR_CLK_CTRL);
  wire wrIosc = wrDone && (paddr == `SCC_ADDR_INT_OSC);
  wire wrTrim = wrDone && (paddr == `SCC_ADDR_INT_TRIM);
  wire wrExt  = wrDone && (paddr == `SCC_ADDR_EXT_OSC);

  wire [2:0] wrSel = pwdata[`SCC_SEL_MSB:`SCC_SEL_LSB];
  wire [2:0] wrDiv = pwdata[`SCC_DIV_MSB:`SCC_DIV_LSB];

  reg  [31:0] next_prdata;
  reg         next_pslverr;

  always @* begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      `SCC_ADDR_CLK_CTRL: begin
        next_prdata[`SCC_SEL_MSB:`SCC_SEL_LSB] = selReg;
        next_prdata[`SCC_DIV_MSB:`SCC_DIV_LSB] = divReg;
        next_prdata[`SCC_RDY_BIT]              = divApplied;
      end
      `SCC_ADDR_INT_OSC: begin
        next_prdata[`SCC_IOSC_EN_BIT]  = precOscEnable;
        next_prdata[`SCC_IOSC_RDY_BIT] = precOscEnable;
      end
      `SCC_ADDR_INT_TRIM: begin
        next_prdata[`SCC_TRIM_MSB:`SCC_TRIM_LSB] = precTrim;
        next_prdata[`SCC_SSE_BIT]                = spreadEnable;
      end
      `SCC_ADDR_EXT_OSC: begin
        next_prdata[`SCC_XMODE_MSB:`SCC_XMODE_LSB] = extOscMode;
        next_prdata[`SCC_XDRV_MSB:`SCC_XDRV_LSB]   = extDriveLevel;
        next_prdata[`SCC_XVLD_BIT]                 = extValid;
      end
      default: begin
        next_pslverr = 1'b1;
      end
    endcase
  end

  // apb answers one cycle into the access phase
  always @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apbAccess;
      pslverr <= apbAccess & next_pslverr;
      if (apbAccess && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // control fields written by software
  always @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      selReg        <= `SCC_SEL_RESET;
      divReg        <= `SCC_DIV_RESET;
      precOscEnable <= 1'b0;
      precTrim      <= TRIM_FACTORY;
      spreadEnable  <= 1'b0;
      extOscMode    <= `SCC_XMODE_OFF;
      extDriveLevel <= 3'h0;
    end else begin
      if (wrClk) begin
        if (legalSource(wrSel)) begin
          selReg <= wrSel;
        end
        divReg <= wrDiv;
      end
      if (wrIosc) begin
        precOscEnable <= pwdata[`SCC_IOSC_EN_BIT];
      end
      if (wrTrim) begin
        precTrim     <= pwdata[`SCC_TRIM_MSB:`SCC_TRIM_LSB];
        spreadEnable <= pwdata[`SCC_SSE_BIT];
      end
      if (wrExt) begin
        extOscMode    <= pwdata[`SCC_XMODE_MSB:`SCC_XMODE_LSB];
        extDriveLevel <= pwdata[`SCC_XDRV_MSB:`SCC_XDRV_LSB];
      end
    end
  end

  // ---------------------------------------------------------------
  // external oscillator
  // ---------------------------------------------------------------
  reg extHalf;
  wire extOn = (extOscMode != `SCC_XMODE_OFF);
  wire [VCNT_W-1:0] validLimit = EXT_VALID_TICKS[VCNT_W-1:0] - 1'b1;

  wire extTickMode = (extOscMode == `SCC_XMODE_XTAL_DIV2) ? (extOscTick & extHalf)
                                                          : extOscTick;
  wire extSrcTick  = extOn & extValid & extTickMode;

  always @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      extHalf        <= 1'b0;
      validCnt       <= {VCNT_W{1'b0}};
      extValid       <= 1'b0;
      extOscEnable   <= 1'b0;
      extUsesPinA    <= 1'b0;
      extPeriphClkEn <= 1'b0;
    end else begin
      extOscEnable <= extOn;
      extUsesPinA  <= (extOscMode == `SCC_XMODE_XTAL) ||
                      (extOscMode == `SCC_XMODE_XTAL_DIV2);
      if (extOscTick) begin
        extHalf <= ~extHalf;
      end
      if (!extOn) begin
        validCnt <= {VCNT_W{1'b0}};
        extValid <= 1'b0;
      end else if (extOscTick && !extValid) begin
        if (validCnt == validLimit) begin
          extValid <= 1'b1;
        end else begin
          validCnt <= validCnt + 1'b1;
        end
      end
      // clock for timers and counter array
      extPeriphClkEn <= extSrcTick;
    end
  end

  // ---------------------------------------------------------------
  // spread spectrum
  // ---------------------------------------------------------------
  reg [4:0] ssCnt;
  reg       ssDown;

  always @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      ssCnt          <= 5'h00;
      ssDown         <= 1'b0;
      precSpreadStep <= 3'h0;
    end else if (!spreadEnable || !precOscEnable) begin
      ssCnt          <= 5'h00;
      ssDown         <= 1'b0;
      precSpreadStep <= 3'h0;
    end else if (precOscTick) begin
      // 12 steps per 384 oscillator cycles
      if (ssCnt == (`SCC_SS_STEP_TICKS - 1)) begin
        ssCnt <= 5'h00;
        if (!ssDown) begin
          precSpreadStep <= precSpreadStep + 3'h1;
          if (precSpreadStep == (`SCC_SS_STEPS - 1)) begin
            ssDown <= 1'b1;
          end
        end else begin
          precSpreadStep <= precSpreadStep - 3'h1;
          if (precSpreadStep == 3'h1) begin
            ssDown <= 1'b0;
          end
        end
      end else begin
        ssCnt <= ssCnt + 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // source switch and divider
  // ---------------------------------------------------------------
  reg  [1:0] swState;
  reg  [2:0] activeSel;
  reg  [2:0] activeDiv;
  reg  [`SCC_DIV_CNT_W-1:0] divCnt;

  wire precSrcTick = precOscEnable & precOscTick;
  wire lpSrcTick   = lpOscEnable & lpOscTick;
  wire oldTick = pickTick(activeSel, precSrcTick, extSrcTick, rtcOscTick, lpSrcTick);
  wire newTick = pickTick(selReg, precSrcTick, extSrcTick, rtcOscTick, lpSrcTick);
  wire divWrap = oldTick && (swState == SW_IDLE) && (divCnt == divLimit(activeDiv));

  always @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      swState     <= SW_IDLE;
      activeSel   <= `SCC_SEL_RESET;
      activeDiv   <= `SCC_DIV_RESET;
      divCnt      <= {`SCC_DIV_CNT_W{1'b0}};
      divApplied  <= 1'b0;
      coreClkEn   <= 1'b0;
      lpOscEnable <= 1'b1;
    end else begin
      // runs while selected or still in use
      lpOscEnable <= (selReg == `SCC_SRC_LP) || (activeSel == `SCC_SRC_LP);
      coreClkEn   <= 1'b0;
      case (swState)
        SW_IDLE: begin
          if (activeSel != selReg) begin
            swState <= SW_WAIT_OLD;
          end else if (oldTick) begin
            // one core pulse per 2^n source ticks
            if (divWrap) begin
              divCnt    <= {`SCC_DIV_CNT_W{1'b0}};
              coreClkEn <= 1'b1;
              activeDiv <= divReg;
            end else begin
              divCnt <= divCnt + 1'b1;
            end
          end
        end
        SW_WAIT_OLD: begin
          // finish current period of old source
          if (oldTick) begin
            swState <= SW_WAIT_NEW;
          end
        end
        SW_WAIT_NEW: begin
          // resume on a fresh edge of new source
          if (newTick) begin
            swState   <= SW_IDLE;
            activeSel <= selReg;
            divCnt    <= {`SCC_DIV_CNT_W{1'b0}};
            coreClkEn <= 1'b1;
            activeDiv <= divReg;
          end
        end
        default: begin
          swState <= SW_IDLE;
        end
      endcase
      // flag low until the written divide value is in use
      if (wrClk && (wrDiv != activeDiv)) begin
        divApplied <= 1'b0;
      end else if (activeDiv == divReg) begin
        divApplied <= 1'b1;
      end else begin
        divApplied <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== scc_defines.vh ====
// constants for the system clock source control block
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH

// register byte addresses
`define SCC_ADDR_CLK_CTRL   8'h00
`define SCC_ADDR_INT_OSC    8'h04
`define SCC_ADDR_INT_TRIM   8'h08
`define SCC_ADDR_EXT_OSC    8'h0C

// clock control fields
`define SCC_SEL_LSB         0
`define SCC_SEL_MSB         2
`define SCC_DIV_LSB         4
`define SCC_DIV_MSB         6
`define SCC_RDY_BIT         7

// source select codes
`define SCC_SRC_PREC        3'h0
`define SCC_SRC_EXT         3'h1
`define SCC_SRC_RTC         3'h3
`define SCC_SRC_LP          3'h4

// reset values of the clock control fields
`define SCC_SEL_RESET       3'h4
`define SCC_DIV_RESET       3'h3

// internal oscillator control fields
`define SCC_IOSC_EN_BIT     0
`define SCC_IOSC_RDY_BIT    1

// trim register fields
`define SCC_TRIM_LSB        0
`define SCC_TRIM_MSB        6
`define SCC_SSE_BIT         7

// external oscillator config fields
`define SCC_XMODE_LSB       0
`define SCC_XMODE_MSB       1
`define SCC_XDRV_LSB        4
`define SCC_XDRV_MSB        6
`define SCC_XVLD_BIT        7

// external oscillator modes
`define SCC_XMODE_OFF       2'h0
`define SCC_XMODE_XTAL      2'h1
`define SCC_XMODE_XTAL_DIV2 2'h2
`define SCC_XMODE_RC        2'h3

// spread spectrum: 384 oscillator cycles per triangle, 6 steps of 0.26 % = 1.6 %
`define SCC_SS_PERIOD       384
`define SCC_SS_STEPS        6
`define SCC_SS_STEP_TICKS   (`SCC_SS_PERIOD / (2 * `SCC_SS_STEPS))

// widest divider: 2^7 = 128
`define SCC_DIV_CNT_W       7

`endif

// ==== scc_clock_control_assertions.sv ====
// assertion checker for the clock source control block
`timescale 1ns/1ps
`default_nettype none
module scc_checker #(
  parameter [6:0] TRIM_FACTORY = 7'h40
) (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [6:0] precTrim,
  input wire logic [2:0] precSpreadStep,
  input wire logic       lpOscEnable,
  input wire logic       extOscEnable,
  input wire logic [1:0] extOscMode,
  input wire logic       extUsesPinA,
  input wire logic       extPeriphClkEn
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // -------------------------
  // bus answer
  // -------------------------
  sequence s_oneWait;
    !pready ##1 pready ##1 !pready;
  endsequence
  AST_PREADY_WAIT: assert property ($rose(penable) && psel |-> s_oneWait)
    else $error("pready not a single pulse in second access cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an answered access");
  // -------------------------
  // oscillators
  // -------------------------
  AST_TRIM_RESET: assert property (
    $rose(rst_b) |-> precTrim == TRIM_FACTORY) else $error("trim not factory value");
  AST_LP_RESET: assert property (
    $rose(rst_b) |-> lpOscEnable) else $error("low-power oscillator off after reset");
  AST_PIN_A_XTAL: assert property (
    extUsesPinA == ($past(extOscMode) == 2'h1 || $past(extOscMode) == 2'h2))
    else $error("pin a use does not follow crystal mode");
  AST_RC_PIN_B: assert property (
    $past(extOscMode) == 2'h3 |-> !extUsesPinA) else $error("rc mode touches pin a");
  AST_EXT_ENABLE: assert property (
    extOscEnable == ($past(extOscMode) != 2'h0)) else $error("ext enable not tied to mode");
  AST_PERIPH_EXT: assert property (
    extPeriphClkEn |-> $past(extOscMode) != 2'h0) else $error("peripheral tick with ext off");
  AST_SPREAD_MAX: assert property (
    precSpreadStep <= 3'h6) else $error("spread step beyond six");
  AST_SPREAD_STEP: assert property (
    $changed(precSpreadStep) |-> precSpreadStep == $past(precSpreadStep) + 3'h1
      || precSpreadStep == $past(precSpreadStep) - 3'h1 || precSpreadStep == 3'h0)
    else $error("spread step jumped");
endmodule
bind scc_clock_control scc_checker #(.TRIM_FACTORY(TRIM_FACTORY)) u_chk (
  .sys_clk, .rst_b, .psel, .penable, .pready, .pslverr, .precTrim, .precSpreadStep,
  .lpOscEnable, .extOscEnable, .extOscMode, .extUsesPinA, .extPeriphClkEn);
`default_nettype wire

// ==== system_clock_source_control_bench.sv ====
// self-checking bench for the clock source control block
`timescale 1ns/1ps
`default_nettype none
`include "scc_defines.vh"
module system_clock_source_control_bench;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, precOscEnable, lpOscEnable, extOscEnable, extUsesPinA;
  logic precOscTick = 0, extOscTick = 0, lpOscTick = 0, rtcOscTick = 0;
  logic coreClkEn, extPeriphClkEn;
  logic [6:0] precTrim;
  logic [2:0] precSpreadStep, extDriveLevel;
  logic [1:0] extOscMode;
  logic [64:0] expQ[$];
  logic [64:0] q;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, k, n, m, r;
  int src[4] = '{0, 3, 2, 4};
  int per[4] = '{2, 7, 7, 3};
  scc_clock_control #(.EXT_VALID_TICKS(4)) u_dut (.sys_clk, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .precOscTick, .extOscTick,
    .lpOscTick, .rtcOscTick, .precOscEnable, .precTrim, .precSpreadStep, .lpOscEnable,
    .extOscEnable, .extOscMode, .extDriveLevel, .extUsesPinA, .coreClkEn,
    .extPeriphClkEn);
  always #5 sys_clk = ~sys_clk;
  // oscillator ticks with fixed periods 2, 5, 3, 7
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    precOscTick <= (cyc % 2 == 0);
    extOscTick <= (cyc % 5 == 0);
    lpOscTick <= (cyc % 3 == 0);
    rtcOscTick <= (cyc % 7 == 0);
  end
  // -------------------------
  // tasks
  // -------------------------
  task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_reg(input logic [64:0] x, input logic [31:0] g, input logic er);
    samples_checked++;
    if ((g & x[63:32]) !== (x[31:0] & x[63:32]) || er !== x[64]) begin
      n_mismatch++;
      $display("mismatch prdata exp %h err %b got %h err %b", x[31:0], x[64], g, er);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] msk, input logic e, output logic [31:0] o);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    expQ.push_back({e, w ? 32'h0 : msk, d});
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    o = prdata;
    psel <= 0;
    penable <= 0;
    #1;
  endtask
  task automatic poll(input logic [7:0] a, input int b);
    int i;
    i = 0;
    rd = 0;
    while (rd[b] !== 1'b1 && i < 300) begin
      apb(0, a, 0, 0, 0, rd);
      i++;
    end
    cmp_val("poll", 1, rd[b]);
  endtask
  // cycles between the 2nd and 3rd pulse seen
  task automatic gap(input bit x, output int c);
    for (int j = 0; j < 3; j++) begin
      c = 0;
      do begin
        @(posedge sys_clk);
        c++;
      end while ((x ? extPeriphClkEn : coreClkEn) !== 1'b1 && c < 3000);
    end
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1) begin
      q = expQ.pop_front();
      cmp_reg(q, prdata, pslverr);
    end
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end
  // -------------------------
  // tests
  // -------------------------
  initial begin
    void'($urandom(32'h7FFAECF2));
    repeat (4) @(posedge sys_clk);
    rst_b <= 1;
    repeat (4) @(posedge sys_clk);
    apb(0, `SCC_ADDR_CLK_CTRL, 32'h34, 32'hFFFFFF7F, 0, rd);
    apb(0, `SCC_ADDR_INT_TRIM, 32'h40, ALL, 0, rd);
    apb(0, `SCC_ADDR_EXT_OSC, 0, ALL, 0, rd);
    cmp_val("lpOscEnable", 1, lpOscEnable);
    apb(0, 8'h10, 0, 0, 1, rd);
    apb(1, 8'h10, 32'hFF, 0, 1, rd);
    for (k = 7; k >= 0; k--) begin
      apb(1, `SCC_ADDR_CLK_CTRL, (k << 4) | 4, 0, 0, rd);
      poll(`SCC_ADDR_CLK_CTRL, 7);
      gap(0, n);
      cmp_val("coreGap", 3 << k, n);
    end
    apb(1, `SCC_ADDR_INT_OSC, 1, 0, 0, rd);
    apb(0, `SCC_ADDR_INT_OSC, 3, 3, 0, rd);
    cmp_val("precOscEnable", 1, precOscEnable);
    // reserved code 2 must leave the rtc source in place
    for (k = 0; k < 4; k++) begin
      apb(1, `SCC_ADDR_CLK_CTRL, src[k], 0, 0, rd);
      gap(0, n);
      cmp_val("coreGap", per[k], n);
      cmp_val("lpOscEnable", src[k] == 4, lpOscEnable);
    end
    for (k = 0; k < 8; k++) begin
      apb(1, `SCC_ADDR_EXT_OSC, (k << 4) | 3, 0, 0, rd);
      cmp_val("extDriveLevel", k, extDriveLevel);
      cmp_val("extUsesPinA", 0, extUsesPinA);
    end
    r = $urandom_range(7);
    apb(1, `SCC_ADDR_EXT_OSC, 0, 0, 0, rd);
    apb(1, `SCC_ADDR_EXT_OSC, (r << 4) | 1, 0, 0, rd);
    apb(0, `SCC_ADDR_EXT_OSC, (r << 4) | 1, ALL, 0, rd);
    cmp_val("extUsesPinA", 1, extUsesPinA);
    poll(`SCC_ADDR_EXT_OSC, 7);
    apb(1, `SCC_ADDR_CLK_CTRL, 1, 0, 0, rd);
    gap(0, n);
    cmp_val("coreGap", 5, n);
    apb(1, `SCC_ADDR_EXT_OSC, (r << 4) | 2, 0, 0, rd);
    poll(`SCC_ADDR_EXT_OSC, 7);
    gap(1, n);
    cmp_val("periphGap", 10, n);
    gap(0, n);
    cmp_val("coreGap", 10, n);
    // slow to fast: source first, then divide, then poll
    apb(1, `SCC_ADDR_CLK_CTRL, 32'h00, 0, 0, rd);
    apb(1, `SCC_ADDR_CLK_CTRL, 32'h20, 0, 0, rd);
    poll(`SCC_ADDR_CLK_CTRL, 7);
    gap(0, n);
    cmp_val("coreGap", 8, n);
    // fast to slow: divide, poll, then source
    apb(1, `SCC_ADDR_CLK_CTRL, 32'h10, 0, 0, rd);
    poll(`SCC_ADDR_CLK_CTRL, 7);
    apb(1, `SCC_ADDR_CLK_CTRL, 32'h14, 0, 0, rd);
    gap(0, n);
    cmp_val("coreGap", 6, n);
    cmp_val("lpOscEnable", 1, lpOscEnable);
    // rc start: configure, poll valid, then switch
    r = $urandom_range(7);
    apb(1, `SCC_ADDR_EXT_OSC, 0, 0, 0, rd);
    apb(1, `SCC_ADDR_EXT_OSC, (r << 4) | 3, 0, 0, rd);
    cmp_val("extOscMode", 3, extOscMode);
    poll(`SCC_ADDR_EXT_OSC, 7);
    cmp_val("extOscEnable", 1, extOscEnable);
    apb(1, `SCC_ADDR_CLK_CTRL, 32'h11, 0, 0, rd);
    gap(0, n);
    cmp_val("coreGap", 10, n);
    cmp_val("lpOscEnable", 0, lpOscEnable);
    cmp_val("extUsesPinA", 0, extUsesPinA);
    r = $urandom_range(127);
    apb(1, `SCC_ADDR_INT_TRIM, 128 | r, 0, 0, rd);
    apb(0, `SCC_ADDR_INT_TRIM, 128 | r, ALL, 0, rd);
    cmp_val("precTrim", r, precTrim);
    // time between rises of the spread step from 0 to 1
    k = 0;
    n = 0;
    m = 0;
    while (k < 4 && n < 3000) begin
      @(posedge sys_clk);
      n++;
      if (precSpreadStep > m)
        m = precSpreadStep;
      if ((precSpreadStep === 3'h0) == (k % 2 == 0)) begin
        k++;
        if (k == 2)
          n = 0;
      end
    end
    cmp_val("spreadPeriod", 768, n);
    cmp_val("spreadMax", 6, m);
    results();
  end
endmodule
`default_nettype wire
